// File: core/fault_code_pkg.sv
// Purpose: Constants for the instruction fault status encoder.
// Assumes: One clock, mclk at 40 MHz; asynchronous active-low reset.
// Notes: Fault codes are six bits; syndrome bit six is reserved.
//
// How it works
// - Six-bit status code sits in syndrome bits 5:0, bit 6 reserved.
// - Address size fault is 0b0000LL; level 0 also covers table base.
// - Translation fault is 0b0001LL for lookup levels 0 to 3.
// - Access flag fault at levels 1 to 3 is 0b001001 to 0b001011.
// - Permission fault at levels 1 to 3 is 0b001101 to 0b001111.
// - Level -1 and level 0 flag/permission codes need large address option.
// - External abort 0b010000; walk abort 0b0101LL, level -1 0b010011.
// - Parity/ECC codes only without reliability option; 0b011000, 0b0111LL.
// - Granule protection walk fault 0b1001LL; level -1 0b100011 needs both.
// - Granule protection fault outside a walk is 0b101000.
// - TLB conflict 0b110000; unsupported atomic update 0b110001 if option.
// - Never output a reserved code value.
// - No access flag or permission fault at level 0 in base setup.
// - With stage one walk flag set, level is the stage two level.
// - Status code value after warm reset is not relied upon.
package fault_code_pkg;

  // Fault classes presented by the walker and memory system
  typedef enum logic [3:0] {
    FK_ADDR_SIZE,
    FK_TRANSLATION,
    FK_ACCESS_FLAG,
    FK_PERMISSION,
    FK_EXT_ABORT,
    FK_EXT_WALK,
    FK_PARITY,
    FK_PARITY_WALK,
    FK_GPF_WALK,
    FK_GPF,
    FK_TLB_CONFLICT,
    FK_ATOMIC_HW
  } fault_kind_type;

  // Lookup level field: 3'h7 encodes level -1
  localparam logic [2:0] LVL_MINUS_ONE = 3'h7;

  localparam logic [5:0] FSC_ADDR_SIZE = 6'h00;
  localparam logic [5:0] FSC_TRANSLATION = 6'h04;
  localparam logic [5:0] FSC_ACCESS_FLAG = 6'h08;
  localparam logic [5:0] FSC_PERMISSION = 6'h0C;
  localparam logic [5:0] FSC_EXT_ABORT = 6'h10;
  localparam logic [5:0] FSC_EXT_WALK_M1 = 6'h13;
  localparam logic [5:0] FSC_EXT_WALK = 6'h14;
  localparam logic [5:0] FSC_PARITY = 6'h18;
  localparam logic [5:0] FSC_PARITY_WALK_M1 = 6'h1B;
  localparam logic [5:0] FSC_PARITY_WALK = 6'h1C;
  localparam logic [5:0] FSC_GPF_WALK_M1 = 6'h23;
  localparam logic [5:0] FSC_GPF_WALK = 6'h24;
  localparam logic [5:0] FSC_GPF = 6'h28;
  localparam logic [5:0] FSC_ADDR_SIZE_M1 = 6'h29;
  localparam logic [5:0] FSC_TRANSLATION_M1 = 6'h2B;
  localparam logic [5:0] FSC_TLB_CONFLICT = 6'h30;
  localparam logic [5:0] FSC_ATOMIC_HW = 6'h31;

  // Reset value of held code; any value is legal, zero chosen
  localparam logic [5:0] FSC_RESET = 6'h00;
  localparam logic SYN_BIT6_VALUE = 1'h0;

endpackage

// File: core/instruction_fault_status_encoder.sv
// Purpose: Encode an instruction abort cause into the six-bit status code.
// Assumes: Fault inputs come from logic on mclk; option straps are static.
// Notes: A combination that has no defined code is dropped, not reported.
`timescale 1ns/1ps

module instruction_fault_status_encoder (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Feature options
  input wire logic large_phys_addr_option,
  input wire logic reliability_error_option,
  input wire logic realm_management_option,
  input wire logic hw_access_dirty_update_option,
  // Fault report from walker and memory system
  input wire logic fault_valid,
  input wire fault_code_pkg::fault_kind_type fault_kind,
  input wire logic [2:0] fault_level,
  input wire logic stage_one_walk_flag,
  input wire logic [2:0] s2_level,
  // Syndrome output
  output logic syndrome_valid,
  output logic fault_dropped,
  output logic [6:0] syndrome_low,
  output logic [5:0] instr_fault_status_code
);

  // ----------------------------------------------------------------
  // Level selection and option gating
  // ----------------------------------------------------------------
  // Walk faults on stage two report the stage two level
  wire logic [2:0] level_used = stage_one_walk_flag ? s2_level
                                                    : fault_level;
  wire logic lvl_m1 = (level_used == fault_code_pkg::LVL_MINUS_ONE);
  wire logic lvl_0 = (level_used == 3'h0);
  wire logic lvl_ok = !level_used[2];
  wire logic [5:0] ll = {4'h0, level_used[1:0]};
  wire logic lpa = large_phys_addr_option;
  wire logic par_ok = !reliability_error_option;

  logic [5:0] code;
  logic legal;

  // ----------------------------------------------------------------
  // Encoder
  // ----------------------------------------------------------------
  always_comb begin
    code = fault_code_pkg::FSC_TLB_CONFLICT;
    legal = 1'b0;
    unique case (fault_kind)
      fault_code_pkg::FK_ADDR_SIZE: begin
        legal = lvl_ok || (lvl_m1 && lpa);
        code = lvl_m1 ? fault_code_pkg::FSC_ADDR_SIZE_M1
                      : fault_code_pkg::FSC_ADDR_SIZE | ll;
      end
      fault_code_pkg::FK_TRANSLATION: begin
        legal = lvl_ok || (lvl_m1 && lpa);
        code = lvl_m1 ? fault_code_pkg::FSC_TRANSLATION_M1
                      : fault_code_pkg::FSC_TRANSLATION | ll;
      end
      fault_code_pkg::FK_ACCESS_FLAG: begin
        legal = lvl_ok && (!lvl_0 || lpa);
        code = fault_code_pkg::FSC_ACCESS_FLAG | ll;
      end
      fault_code_pkg::FK_PERMISSION: begin
        legal = lvl_ok && (!lvl_0 || lpa);
        code = fault_code_pkg::FSC_PERMISSION | ll;
      end
      fault_code_pkg::FK_EXT_ABORT: begin
        legal = 1'b1;
        code = fault_code_pkg::FSC_EXT_ABORT;
      end
      fault_code_pkg::FK_EXT_WALK: begin
        legal = lvl_ok || (lvl_m1 && lpa);
        code = lvl_m1 ? fault_code_pkg::FSC_EXT_WALK_M1
                      : fault_code_pkg::FSC_EXT_WALK | ll;
      end
      fault_code_pkg::FK_PARITY: begin
        legal = par_ok;
        code = fault_code_pkg::FSC_PARITY;
      end
      fault_code_pkg::FK_PARITY_WALK: begin
        legal = par_ok && (lvl_ok || (lvl_m1 && lpa));
        code = lvl_m1 ? fault_code_pkg::FSC_PARITY_WALK_M1
                      : fault_code_pkg::FSC_PARITY_WALK | ll;
      end
      fault_code_pkg::FK_GPF_WALK: begin
        legal = realm_management_option && (lvl_ok || (lvl_m1 && lpa));
        code = lvl_m1 ? fault_code_pkg::FSC_GPF_WALK_M1
                      : fault_code_pkg::FSC_GPF_WALK | ll;
      end
      fault_code_pkg::FK_GPF: begin
        legal = realm_management_option;
        code = fault_code_pkg::FSC_GPF;
      end
      fault_code_pkg::FK_TLB_CONFLICT: begin
        legal = 1'b1;
        code = fault_code_pkg::FSC_TLB_CONFLICT;
      end
      fault_code_pkg::FK_ATOMIC_HW: begin
        legal = hw_access_dirty_update_option;
        code = fault_code_pkg::FSC_ATOMIC_HW;
      end
      default: begin
        legal = 1'b0;
        code = fault_code_pkg::FSC_TLB_CONFLICT;
      end
    endcase
  end

  // Illegal combinations never reach the field, so no reserved code leaks
  wire logic take = fault_valid && legal;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic [5:0] code_q;
  logic valid_q;
  logic drop_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= fault_code_pkg::FSC_RESET;
      valid_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      if (take) begin
        code_q <= code;
      end
      valid_q <= take;
      drop_q <= fault_valid && !legal;
    end
  end

  assign instr_fault_status_code = code_q;
  assign syndrome_low = {fault_code_pkg::SYN_BIT6_VALUE, code_q};
  assign syndrome_valid = valid_q;
  assign fault_dropped = drop_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  function automatic logic defined_code(input logic [5:0] c);
    defined_code = (c <= 6'h07) || (c >= 6'h08 && c <= 6'h13) ||
                   (c >= 6'h14 && c <= 6'h18) || (c >= 6'h1B && c <= 6'h1F)
                   || (c >= 6'h23 && c <= 6'h29) || c == 6'h2B ||
                   c == 6'h30 || c == 6'h31;
  endfunction

  code_defined_a: assert property (@(posedge mclk) disable iff (!rst_n)
    syndrome_valid |-> defined_code(instr_fault_status_code) &&
    !(instr_fault_status_code inside {6'h11, 6'h12}))
    else $error("reserved status code reported");
  bit_six_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    syndrome_low[6] == 1'b0 &&
    syndrome_low[5:0] == instr_fault_status_code)
    else $error("syndrome bit six not zero");
  trans_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_TRANSLATION &&
    !stage_one_walk_flag && !fault_level[2]
    |=> syndrome_valid &&
    instr_fault_status_code == {4'h1, $past(fault_level[1:0])})
    else $error("translation level code wrong");
  addr_size_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_ADDR_SIZE &&
    !stage_one_walk_flag && !fault_level[2]
    |=> instr_fault_status_code == {4'h0, $past(fault_level[1:0])})
    else $error("address size code wrong");
  af_level0_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && !large_phys_addr_option && level_used == 3'h0 &&
    fault_kind inside {fault_code_pkg::FK_ACCESS_FLAG,
                       fault_code_pkg::FK_PERMISSION}
    |=> !syndrome_valid && fault_dropped)
    else $error("level zero flag fault reported");
  lpa_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    syndrome_valid && !$past(large_phys_addr_option) |->
    !(instr_fault_status_code inside {6'h08, 6'h0C, 6'h13, 6'h1B,
                                      6'h23, 6'h29, 6'h2B}))
    else $error("large address code without option");
  parity_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    syndrome_valid && $past(reliability_error_option) |->
    instr_fault_status_code[5:3] != 3'h3)
    else $error("parity code with reliability option");
  realm_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    syndrome_valid && !$past(realm_management_option) |->
    !(instr_fault_status_code inside {[6'h23:6'h28]}))
    else $error("granule code without realm option");
  gpf_plain_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_GPF &&
    realm_management_option |=> instr_fault_status_code == 6'h28)
    else $error("granule fault code wrong");
  tlb_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_TLB_CONFLICT
    |=> syndrome_valid && instr_fault_status_code == 6'h30)
    else $error("tlb conflict code wrong");
  ext_walk_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_EXT_WALK &&
    stage_one_walk_flag && !s2_level[2]
    |=> instr_fault_status_code == {4'h5, $past(s2_level[1:0])})
    else $error("stage two walk level wrong");
  hold_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !take |=> $stable(instr_fault_status_code))
    else $error("status code changed without fault");

  // ----------------------------------------------------------------
  // Class and level codes
  // ----------------------------------------------------------------
  // Direct faults only, except ext_m1_a, which uses level_used; the stage two level path is checked below
  af_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_ACCESS_FLAG &&
    !stage_one_walk_flag && fault_level inside {3'h1, 3'h2, 3'h3}
    |=> syndrome_valid &&
    instr_fault_status_code == {4'h2, $past(fault_level[1:0])})
    else $error("access flag code wrong");
  perm_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_PERMISSION &&
    !stage_one_walk_flag && fault_level inside {3'h1, 3'h2, 3'h3}
    |=> syndrome_valid &&
    instr_fault_status_code == {4'h3, $past(fault_level[1:0])})
    else $error("permission code wrong");
  ext_abort_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_EXT_ABORT
    |=> syndrome_valid && instr_fault_status_code == 6'h10)
    else $error("external abort code wrong");
  ext_m1_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_EXT_WALK &&
    large_phys_addr_option && level_used == fault_code_pkg::LVL_MINUS_ONE
    |=> syndrome_valid && instr_fault_status_code == 6'h13)
    else $error("walk abort level minus one wrong");
  gpf_walk_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_GPF_WALK &&
    realm_management_option && !stage_one_walk_flag && !fault_level[2]
    |=> syndrome_valid &&
    instr_fault_status_code == {4'h9, $past(fault_level[1:0])})
    else $error("granule walk code wrong");

  // ----------------------------------------------------------------
  // Large address and stage two levels
  // ----------------------------------------------------------------
  // Level -1 codes exist only with the large address option
  trans_m1_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_TRANSLATION &&
    large_phys_addr_option && level_used == fault_code_pkg::LVL_MINUS_ONE
    |=> syndrome_valid && instr_fault_status_code == 6'h2B)
    else $error("translation level minus one wrong");
  addr_m1_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_ADDR_SIZE &&
    large_phys_addr_option && level_used == fault_code_pkg::LVL_MINUS_ONE
    |=> syndrome_valid && instr_fault_status_code == 6'h29)
    else $error("address size level minus one wrong");
  s2_trans_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_TRANSLATION &&
    stage_one_walk_flag && !s2_level[2]
    |=> syndrome_valid &&
    instr_fault_status_code == {4'h1, $past(s2_level[1:0])})
    else $error("stage two translation level wrong");

  // ----------------------------------------------------------------
  // Option gating
  // ----------------------------------------------------------------
  // An option must both allow its code when present and hide it when not; parity codes show only while their option is absent
  parity_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_PARITY &&
    !reliability_error_option
    |=> syndrome_valid && instr_fault_status_code == 6'h18)
    else $error("parity code wrong");
  parity_walk_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_PARITY_WALK &&
    !reliability_error_option && !stage_one_walk_flag && !fault_level[2]
    |=> syndrome_valid &&
    instr_fault_status_code == {4'h7, $past(fault_level[1:0])})
    else $error("parity walk code wrong");
  atomic_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid && fault_kind == fault_code_pkg::FK_ATOMIC_HW &&
    hw_access_dirty_update_option
    |=> syndrome_valid && instr_fault_status_code == 6'h31)
    else $error("atomic update code wrong");
  atomic_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    syndrome_valid && !$past(hw_access_dirty_update_option) |->
    instr_fault_status_code != 6'h31)
    else $error("atomic code without option");

  // ----------------------------------------------------------------
  // Answer handshake
  // ----------------------------------------------------------------
  // Every fault gets exactly one answer a cycle later, never a spurious one
  one_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_valid |=> syndrome_valid != fault_dropped)
    else $error("fault answered twice or not at all");
  no_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !fault_valid |=> !syndrome_valid && !fault_dropped)
    else $error("answer without a fault");

  // ----------------------------------------------------------------
  // Scenario covers
  // ----------------------------------------------------------------
  ext_abort_c: cover property (@(posedge mclk) disable iff (!rst_n)
    syndrome_valid && instr_fault_status_code == 6'h10);
  minus_one_c: cover property (@(posedge mclk) disable iff (!rst_n)
    syndrome_valid && instr_fault_status_code == 6'h23);
  dropped_c: cover property (@(posedge mclk) disable iff (!rst_n)
    fault_dropped);
  s2_walk_c: cover property (@(posedge mclk) disable iff (!rst_n)
    take && stage_one_walk_flag ##1 syndrome_valid);
  lpa_level0_c: cover property (@(posedge mclk) disable iff (!rst_n)
    syndrome_valid && instr_fault_status_code == 6'h08);

endmodule

// File: test/walker_model.sv
// Purpose: Walker and memory system model that feeds fault reports.
// Assumes: Bench requests are settled before each falling edge.
// Notes: Fields that no valid pulse qualifies are scrambled every cycle.
`timescale 1ns/1ps

module walker_model (
  // Clock
  input wire logic mclk,
  // Request from the bench
  input wire logic req_valid,
  input wire fault_code_pkg::fault_kind_type req_kind,
  input wire logic [2:0] req_level,
  input wire logic req_flag,
  input wire logic [2:0] req_s2,
  // Fault report to the encoder
  output logic fault_valid,
  output fault_code_pkg::fault_kind_type fault_kind,
  output logic [2:0] fault_level,
  output logic stage_one_walk_flag,
  output logic [2:0] s2_level
);
  initial begin
    fault_valid = 1'h0;
    fault_kind = fault_code_pkg::FK_ADDR_SIZE;
    fault_level = 3'h0;
    stage_one_walk_flag = 1'h0;
    s2_level = 3'h0;
  end

  // Stale fields are inverted so a late sample cannot match by luck
  always @(negedge mclk) begin
    fault_valid <= req_valid;
    if (req_valid) begin
      fault_kind <= req_kind;
      fault_level <= req_level;
      stage_one_walk_flag <= req_flag;
      s2_level <= req_s2;
    end else begin
      fault_kind <= fault_code_pkg::fault_kind_type'(~fault_kind);
      fault_level <= ~fault_level;
      stage_one_walk_flag <= ~stage_one_walk_flag;
      s2_level <= ~s2_level;
    end
  end
endmodule

// File: test/test_instruction_fault_status_encoder.sv
// Purpose: Self-checking bench for the instruction fault status encoder.
// Assumes: Options change only between tests; one fault per cycle.
// Notes: Each test sweeps every class and level, then random traffic.
`timescale 1ns/1ps

module test_instruction_fault_status_encoder;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] opt = 4'h0;
  logic req_valid = 1'h0;
  fault_code_pkg::fault_kind_type req_kind = fault_code_pkg::FK_ADDR_SIZE;
  logic [2:0] req_level = 3'h0;
  logic req_flag = 1'h0;
  logic [2:0] req_s2 = 3'h0;
  logic fault_valid, stage_one_walk_flag, syndrome_valid, fault_dropped;
  fault_code_pkg::fault_kind_type fault_kind;
  logic [2:0] fault_level, s2_level;
  logic [6:0] syndrome_low, want, held;
  logic [5:0] instr_fault_status_code;
  logic [2:0] lvls [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  logic [31:0] seed = 32'h16FBA;
  logic pv, held_ok;
  int n_fail = 0;
  int checks = 0;

  always #12.5 mclk = ~mclk;

  walker_model walker (.mclk(mclk), .req_valid(req_valid),
    .req_kind(req_kind), .req_level(req_level), .req_flag(req_flag),
    .req_s2(req_s2), .fault_valid(fault_valid), .fault_kind(fault_kind),
    .fault_level(fault_level), .stage_one_walk_flag(stage_one_walk_flag),
    .s2_level(s2_level));

  instruction_fault_status_encoder uut (.mclk(mclk), .rst_n(rst_n),
    .large_phys_addr_option(opt[3]), .reliability_error_option(opt[2]),
    .realm_management_option(opt[1]),
    .hw_access_dirty_update_option(opt[0]), .fault_valid(fault_valid),
    .fault_kind(fault_kind), .fault_level(fault_level),
    .stage_one_walk_flag(stage_one_walk_flag), .s2_level(s2_level),
    .syndrome_valid(syndrome_valid), .fault_dropped(fault_dropped),
    .syndrome_low(syndrome_low),
    .instr_fault_status_code(instr_fault_status_code));

  // ----------------------------------------
  // Expected code: bit 6 set when legal
  // ----------------------------------------
  function automatic logic [6:0] expect_code(
      input fault_code_pkg::fault_kind_type k, input logic [2:0] lv,
      input logic [3:0] o);
    logic m1;
    logic [5:0] w;
    m1 = (lv == 3'h7);
    w = {4'h0, lv[1:0]};
    case (k)
      fault_code_pkg::FK_ADDR_SIZE: return m1 ? {o[3], 6'h29} : {1'h1, w};
      fault_code_pkg::FK_TRANSLATION:
        return m1 ? {o[3], 6'h2B} : {1'h1, 6'h04 | w};
      fault_code_pkg::FK_ACCESS_FLAG:
        return {~m1 & (o[3] | lv != 3'h0), 6'h08 | w};
      fault_code_pkg::FK_PERMISSION:
        return {~m1 & (o[3] | lv != 3'h0), 6'h0C | w};
      fault_code_pkg::FK_EXT_ABORT: return 7'h50;
      fault_code_pkg::FK_EXT_WALK:
        return m1 ? {o[3], 6'h13} : {1'h1, 6'h14 | w};
      fault_code_pkg::FK_PARITY: return {~o[2], 6'h18};
      fault_code_pkg::FK_PARITY_WALK:
        return m1 ? {o[3] & ~o[2], 6'h1B} : {~o[2], 6'h1C | w};
      fault_code_pkg::FK_GPF_WALK:
        return m1 ? {o[3] & o[1], 6'h23} : {o[1], 6'h24 | w};
      fault_code_pkg::FK_GPF: return {o[1], 6'h28};
      fault_code_pkg::FK_TLB_CONFLICT: return 7'h70;
      fault_code_pkg::FK_ATOMIC_HW: return {o[0], 6'h31};
      default: return 7'h00;
    endcase
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic cmp_bit(input logic got, input logic exp_v);
    checks++;
    if (got !== exp_v) begin
      n_fail++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp_v);
    end
  endtask

  task automatic cmp_code(input logic [5:0] got, input logic [5:0] exp_v);
    checks++;
    if (got !== exp_v) begin
      n_fail++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp_v);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Stimulus: one test per option setting
  // ----------------------------------------
  initial begin
    held_ok = 1'h0;
    repeat (16) @(negedge mclk);
    rst_n = 1'h1;
    for (int ph = 0; ph < 16; ph++) begin
      opt = ph[3:0];
      // Mid-run reset: the held code is not trusted afterwards
      if (ph == 8) begin
        rst_n = 1'h0;
        repeat (3) @(negedge mclk);
        rst_n = 1'h1;
        held_ok = 1'h0;
      end
      for (int i = 0; i < 90; i++) begin
        @(posedge mclk);
        pv = req_valid;
        want = expect_code(req_kind, req_flag ? req_s2 : req_level, opt);
        seed = xs(seed);
        req_valid = (i < 60) | seed[0];
        // Random kinds include the four unused codes, which must be dropped
        req_kind = fault_code_pkg::fault_kind_type'((i < 60) ? i / 5
          : seed[8:5]);
        req_level = lvls[(i < 60) ? i % 5 : seed[4:2] % 5];
        req_flag = (i >= 60) & seed[9];
        req_s2 = lvls[seed[12:10] % 5];
        @(negedge mclk);
        cmp_bit(syndrome_valid, pv & want[6]);
        cmp_bit(fault_dropped, pv & ~want[6]);
        cmp_bit(syndrome_low[6], 1'h0);
        if (pv & want[6]) begin
          held = want;
          held_ok = 1'h1;
          cmp_code(syndrome_low[5:0], want[5:0]);
        end
        if (held_ok) begin
          cmp_code(instr_fault_status_code, held[5:0]);
        end
      end
      $display("test %0d done, options %h", ph, opt);
    end
    end_of_test();
  end
endmodule
